// ---- core/poc_pkg.sv ----
// Constants, field layout and state types of the proximity offset calibration block.
// Assumes a single 100 MHz clock domain and an 8-bit register port.
package poc_pkg;

	localparam int CLK_MHZ = 100;

	// Register byte addresses
	localparam logic [7:0] ADDR_OFFSET_MAG  = 8'hc0;
	localparam logic [7:0] ADDR_OFFSET_POL  = 8'hc1;
	localparam logic [7:0] ADDR_ZEROING     = 8'hd6;
	localparam logic [7:0] ADDR_CAL_CTRL    = 8'hd7;
	localparam logic [7:0] ADDR_SYS_CTRL    = 8'he0;
	localparam logic [7:0] ADDR_CAL_STATUS  = 8'he1;

	// Reset values
	localparam logic [7:0] RST_OFFSET_MAG   = 8'h00;
	localparam logic       RST_OFFSET_POL   = 1'b0;
	localparam logic [6:0] RST_ZERO_INTVL   = 7'h7f;
	localparam logic [7:0] RST_CAL_CTRL     = 8'h00;
	localparam logic [7:0] RST_SYS_CTRL     = 8'h00;

	// Zeroing control fields
	localparam int BIT_ZERO_TRIG    = 7;
	localparam int ZERO_INTVL_MSB   = 6;
	localparam logic [6:0] ZERO_NEVER      = 7'h00;
	localparam logic [6:0] ZERO_FIRST_ONLY = 7'h7f;

	// Calibration control fields
	localparam int BIT_CAL_AVG      = 7;
	localparam int BIT_CAL_ELEC     = 5;
	localparam int BIT_CAL_PROX_INTEGRATION_TIME    = 4;
	localparam int BIT_CAL_START    = 0;

	// System control fields
	localparam int BIT_PWR          = 0;
	localparam int BIT_ALS_EN       = 1;
	localparam int BIT_PROX_EN      = 2;
	localparam int BIT_APC_DIS      = 3;
	localparam int BIT_SYNC_EN      = 4;
	localparam int BIT_IRQ_EN       = 5;

	// Status fields
	localparam int BIT_DONE         = 0;
	localparam int BIT_CAL_BUSY     = 1;
	localparam int BIT_ZERO_BUSY    = 2;

	// Calibration sequence
	localparam int         CAL_CYCLES   = 9;
	localparam logic [3:0] CAL_LAST_BIT = 4'h8;
	localparam logic [8:0] BIAS_ZERO    = 9'h100;
	localparam int         PROX_W       = 16;
	localparam int         DELAY_W      = 16;

	typedef enum logic [2:0] {
		POC_IDLE,
		POC_WAIT_PWR,
		POC_WAIT_SYNC,
		POC_DELAY,
		POC_MEASURE,
		POC_WAIT_RES
	} poc_state_t;

	typedef struct packed {
		logic [7:0]        mag;
		logic              sign;
		logic              zero_trig;
		logic [6:0]        zero_intvl;
		logic              cal_avg;
		logic              cal_elec;
		logic              cal_prox_integration_time;
		logic              cal_start;
		logic              pwr;
		logic              als_en;
		logic              prox_en;
		logic              apc_dis;
		logic              sync_en;
		logic              irq_en;
		logic              done_flag;
		poc_state_t        state;
		logic [3:0]        bit_idx;
		logic [8:0]        trial;
		logic [DELAY_W-1:0] dly;
		logic              sync_meta;
		logic              sync_s;
		logic              sync_d;
		logic [6:0]        zero_cnt;
		logic              zero_first_done;
		logic              zero_busy;
		logic              zero_req;
		logic              meas_start;
		logic [7:0]        rdata;
		logic              irq;
		logic [PROX_W-1:0] result;
		logic              result_valid;
		logic              diode_off;
		logic              avg_on;
		logic              prox_integration_time_on;
		logic signed [9:0] off_applied;
	} poc_state_reg_t;

endpackage

// ---- core/poc_offset_cal.sv ----
// Proximity offset correction, light-sensing zeroing scheduler and offset calibration sequencer.
// Assumes the measurement engine, light cycle pulses and target come from logic on clock_i;
// only the frame sync pin arrives from outside and is synchronised here.
//
// How it works
// - Eight-bit offset magnitude register, reset zero, software writable.
// - Offset sign in bit 0 of its own register; upper bits read zero.
// - Signed offset from magnitude and sign, range +-255, added to proximity result.
// - Manual zeroing trigger starts a zeroing and clears itself when finished.
// - Seven-bit interval: zero never, 7Fh first cycle only, n every nth cycle.
// - Control bit 7 enables hardware averaging during calibration.
// - Control bit 5 selects electrical-only versus electrical plus optical calibration.
// - Control bit 4 applies integration time during calibration.
// - Writing one to control bit 0 starts calibration.
// - Calibration searches offset bringing result nearest the target.
// - Calibration takes nine proximity measurement cycles.
// - With frame sync enabled, each cycle starts after sync plus start delay.
// - Electrical-only calibration starts at any time, without waiting for power.
// - Electrical-only calibration disconnects the photodiode and skips the power wait; otherwise identical.
// - Completion loads offset registers, clears start bit, sets done flag.
// - Done flag with interrupt enable raises the interrupt output.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none

module poc_offset_cal (
	input  wire logic                        clock_i,
	input  wire logic                        sys_rst_i,
	input  wire logic [7:0]                  reg_addr_i,
	input  wire logic [7:0]                  reg_wdata_i,
	input  wire logic                        reg_wr_i,
	input  wire logic                        reg_rd_i,
	output logic      [7:0]                  reg_rdata_o,
	input  wire logic                        frame_sync_i,
	input  wire logic [poc_pkg::DELAY_W-1:0] prox_start_delay_i,
	input  wire logic [poc_pkg::PROX_W-1:0]  cal_target_i,
	input  wire logic                        meas_done_i,
	input  wire logic [poc_pkg::PROX_W-1:0]  raw_prox_i,
	input  wire logic                        als_cycle_i,
	input  wire logic                        zero_done_i,
	output logic                             meas_start_o,
	output logic [poc_pkg::PROX_W-1:0]       proximity_result_o,
	output logic                             proximity_result_valid_o,
	output logic signed [9:0]                prox_offset_o,
	output logic                             diode_disconnect_o,
	output logic                             cal_averaging_o,
	output logic                             cal_integration_o,
	output logic                             zero_request_o,
	output logic                             power_on_o,
	output logic                             light_sense_enable_o,
	output logic                             prox_measure_enable_o,
	output logic                             pulse_control_disable_o,
	output logic                             irq_o
);

	poc_pkg::poc_state_reg_t s_reg;
	poc_pkg::poc_state_reg_t s_next;

	// Refuse constants that the nine-bit search cannot serve
	if (poc_pkg::CAL_CYCLES != int'(poc_pkg::CAL_LAST_BIT) + 1) begin : g_bad_cycles
		$error("calibration cycle count does not match the search width");
	end
	if (poc_pkg::BIAS_ZERO != (9'h001 << poc_pkg::CAL_LAST_BIT)) begin : g_bad_bias
		$error("search bias is not the top search bit");
	end
	if (poc_pkg::PROX_W < 8) begin : g_bad_result
		$error("result too narrow for the offset");
	end
	if (poc_pkg::DELAY_W < 1) begin : g_bad_delay
		$error("start delay needs at least one bit");
	end

	// Sign-magnitude to two's complement; sign one is negative
	function automatic logic signed [9:0] poc_sm_to_signed(input logic [7:0] m, input logic sg);
		logic signed [9:0] v;
		v = signed'({2'b00, m});
		return sg ? -v : v;
	endfunction

	// Biased search value to signed offset, clamped at -255
	function automatic logic signed [9:0] poc_bias_to_signed(input logic [8:0] b);
		logic signed [9:0] v;
		v = signed'({1'b0, b}) - signed'({1'b0, poc_pkg::BIAS_ZERO});
		return (v < -10'sd255) ? -10'sd255 : v;
	endfunction

	function automatic logic [7:0] poc_read_mux(input poc_pkg::poc_state_reg_t r, input logic [7:0] a);
		logic [7:0] d;
		d = 8'h00;
		unique case (a)
			poc_pkg::ADDR_OFFSET_MAG: d = r.mag;
			poc_pkg::ADDR_OFFSET_POL: d = {7'h00, r.sign};
			poc_pkg::ADDR_ZEROING:    d = {r.zero_trig, r.zero_intvl};
			poc_pkg::ADDR_CAL_CTRL: begin
				d[poc_pkg::BIT_CAL_AVG]   = r.cal_avg;
				d[poc_pkg::BIT_CAL_ELEC]  = r.cal_elec;
				d[poc_pkg::BIT_CAL_PROX_INTEGRATION_TIME] = r.cal_prox_integration_time;
				d[poc_pkg::BIT_CAL_START] = r.cal_start;
			end
			poc_pkg::ADDR_SYS_CTRL: begin
				d[poc_pkg::BIT_PWR]     = r.pwr;
				d[poc_pkg::BIT_ALS_EN]  = r.als_en;
				d[poc_pkg::BIT_PROX_EN] = r.prox_en;
				d[poc_pkg::BIT_APC_DIS] = r.apc_dis;
				d[poc_pkg::BIT_SYNC_EN] = r.sync_en;
				d[poc_pkg::BIT_IRQ_EN]  = r.irq_en;
			end
			poc_pkg::ADDR_CAL_STATUS: begin
				d[poc_pkg::BIT_DONE]      = r.done_flag;
				d[poc_pkg::BIT_CAL_BUSY]  = (r.state != poc_pkg::POC_IDLE);
				d[poc_pkg::BIT_ZERO_BUSY] = r.zero_busy;
			end
			default: d = 8'h00;
		endcase
		return d;
	endfunction

	logic                            wr_mag;
	logic                            wr_pol;
	logic                            wr_zero;
	logic                            wr_cal;
	logic                            wr_sys;
	logic                            wr_stat;
	logic                            cal_finish;
	logic                            sync_edge;
	logic signed [poc_pkg::PROX_W+1:0] corr_sum;
	logic [poc_pkg::PROX_W-1:0]      corr_val;
	logic [8:0]                      trial_bit;
	logic [8:0]                      final_bias;
	logic signed [9:0]               final_off;

	assign wr_mag  = reg_wr_i && (reg_addr_i == poc_pkg::ADDR_OFFSET_MAG);
	assign wr_pol  = reg_wr_i && (reg_addr_i == poc_pkg::ADDR_OFFSET_POL);
	assign wr_zero = reg_wr_i && (reg_addr_i == poc_pkg::ADDR_ZEROING);
	assign wr_cal  = reg_wr_i && (reg_addr_i == poc_pkg::ADDR_CAL_CTRL);
	assign wr_sys  = reg_wr_i && (reg_addr_i == poc_pkg::ADDR_SYS_CTRL);
	assign wr_stat = reg_wr_i && (reg_addr_i == poc_pkg::ADDR_CAL_STATUS);
	assign sync_edge = s_reg.sync_s && !s_reg.sync_d;
	assign trial_bit = 9'h001 << s_reg.bit_idx;

	assign corr_sum = signed'({2'b00, raw_prox_i}) + (poc_pkg::PROX_W+2)'(s_reg.off_applied);
	assign corr_val = (corr_sum < 0) ? '0 : corr_sum[poc_pkg::PROX_W-1:0];

	// keep bit when result not above target
	assign final_bias = (corr_val > cal_target_i) ? (s_reg.trial & ~trial_bit) : s_reg.trial;
	assign final_off  = poc_bias_to_signed(final_bias);
	// Last search bit resolved by this measurement
	assign cal_finish = (s_reg.state == poc_pkg::POC_WAIT_RES) && meas_done_i && (s_reg.bit_idx == 4'h0);

	always_comb begin
		s_next = s_reg;
		s_next.meas_start   = 1'b0;
		s_next.zero_req     = 1'b0;
		s_next.result_valid = 1'b0;
		s_next.rdata        = 8'h00;
		// Frame sync pin passes two flops before the edge detector
		s_next.sync_meta    = frame_sync_i;
		s_next.sync_s       = s_reg.sync_meta;
		s_next.sync_d       = s_reg.sync_s;

		// Read data is zero outside its one-cycle slot
		if (reg_rd_i) begin
			s_next.rdata = poc_read_mux(s_reg, reg_addr_i);
		end
		if (wr_mag) begin
			s_next.mag = reg_wdata_i;
		end
		if (wr_pol) begin
			s_next.sign = reg_wdata_i[0];
		end
		if (wr_zero) begin
			s_next.zero_intvl = reg_wdata_i[poc_pkg::ZERO_INTVL_MSB:0];
			s_next.zero_trig  = reg_wdata_i[poc_pkg::BIT_ZERO_TRIG] | s_reg.zero_trig;
		end
		if (wr_cal) begin
			s_next.cal_avg   = reg_wdata_i[poc_pkg::BIT_CAL_AVG];
			s_next.cal_elec  = reg_wdata_i[poc_pkg::BIT_CAL_ELEC];
			s_next.cal_prox_integration_time = reg_wdata_i[poc_pkg::BIT_CAL_PROX_INTEGRATION_TIME];
			// start on write of one; a running sequence cannot be cancelled
			s_next.cal_start = reg_wdata_i[poc_pkg::BIT_CAL_START] | s_reg.cal_start;
		end
		if (wr_sys) begin
			s_next.pwr     = reg_wdata_i[poc_pkg::BIT_PWR];
			s_next.als_en  = reg_wdata_i[poc_pkg::BIT_ALS_EN];
			s_next.prox_en = reg_wdata_i[poc_pkg::BIT_PROX_EN];
			s_next.apc_dis = reg_wdata_i[poc_pkg::BIT_APC_DIS];
			s_next.sync_en = reg_wdata_i[poc_pkg::BIT_SYNC_EN];
			s_next.irq_en  = reg_wdata_i[poc_pkg::BIT_IRQ_EN];
		end
		if (wr_stat && reg_wdata_i[poc_pkg::BIT_DONE]) begin
			s_next.done_flag = 1'b0;
		end

		// manual zeroing, busy until engine reports done
		// A trigger written in the finishing cycle survives the self-clear
		if (s_reg.zero_trig && !s_reg.zero_busy) begin
			s_next.zero_busy = 1'b1;
			s_next.zero_req  = 1'b1;
		end else if (s_reg.zero_busy && zero_done_i) begin
			s_next.zero_busy = 1'b0;
			s_next.zero_trig = wr_zero && reg_wdata_i[poc_pkg::BIT_ZERO_TRIG];
		end

		// automatic zeroing schedule
		// Count and first-cycle mark restart while light sensing is off
		if (!s_reg.als_en) begin
			s_next.zero_first_done = 1'b0;
			s_next.zero_cnt        = 7'h00;
		end else if (als_cycle_i) begin
			s_next.zero_first_done = 1'b1;
			if (s_reg.zero_intvl == poc_pkg::ZERO_FIRST_ONLY) begin
				s_next.zero_req = s_next.zero_req | !s_reg.zero_first_done;
			end else if (s_reg.zero_intvl != poc_pkg::ZERO_NEVER) begin
				if (s_reg.zero_cnt + 7'h01 >= s_reg.zero_intvl) begin
					s_next.zero_cnt = 7'h00;
					s_next.zero_req = 1'b1;
				end else begin
					s_next.zero_cnt = s_reg.zero_cnt + 7'h01;
				end
			end
		end

		// Corrected result follows every measurement
		if (meas_done_i) begin
			s_next.result       = corr_val;
			s_next.result_valid = 1'b1;
		end

		unique case (s_reg.state)
			poc_pkg::POC_IDLE: begin
				if (s_reg.cal_start) begin
					s_next.bit_idx = poc_pkg::CAL_LAST_BIT;
					s_next.trial   = 9'h000;
					s_next.state   = s_reg.cal_elec ? poc_pkg::POC_WAIT_SYNC : poc_pkg::POC_WAIT_PWR;
				end
			end
			poc_pkg::POC_WAIT_PWR: begin
				// run only once power is on again
				if (s_reg.pwr) begin
					s_next.state = poc_pkg::POC_WAIT_SYNC;
				end
			end
			poc_pkg::POC_WAIT_SYNC: begin
				// Trial bit reaches the front end before the measurement starts
				s_next.trial = s_reg.trial | trial_bit;
				s_next.dly   = prox_start_delay_i;
				if (!s_reg.sync_en) begin
					s_next.state = poc_pkg::POC_MEASURE;
				end else if (sync_edge) begin
					s_next.state = poc_pkg::POC_DELAY;
				end
			end
			poc_pkg::POC_DELAY: begin
				// Start delay counted in clock cycles
				if (s_reg.dly == '0) begin
					s_next.state = poc_pkg::POC_MEASURE;
				end else begin
					s_next.dly = s_reg.dly - 1'b1;
				end
			end
			poc_pkg::POC_MEASURE: begin
				s_next.meas_start = 1'b1;
				s_next.state      = poc_pkg::POC_WAIT_RES;
			end
			poc_pkg::POC_WAIT_RES: begin
				if (meas_done_i) begin
					// Trial bit kept only when the result did not overshoot
					s_next.trial = final_bias;
					// nine cycles, one per search bit
					if (s_reg.bit_idx == 4'h0) begin
						s_next.state = poc_pkg::POC_IDLE;
					end else begin
						s_next.bit_idx = s_reg.bit_idx - 4'h1;
						s_next.state   = poc_pkg::POC_WAIT_SYNC;
					end
				end
			end
		endcase

		// load result, self-clear start, set done; set wins over software clear
		// A start written in the finishing cycle re-arms the sequence
		if (cal_finish) begin
			s_next.mag       = (final_off < 0) ? 8'(-final_off) : 8'(final_off);
			s_next.sign      = (final_off < 0);
			s_next.cal_start = wr_cal && reg_wdata_i[poc_pkg::BIT_CAL_START];
			s_next.done_flag = 1'b1;
		end

		// trial offset drives the front end while calibrating
		// Outside calibration the stored offset drives it
		if (s_next.state != poc_pkg::POC_IDLE) begin
			s_next.off_applied = poc_bias_to_signed(s_next.trial);
		end else begin
			s_next.off_applied = poc_sm_to_signed(s_next.mag, s_next.sign);
		end

		s_next.diode_off = (s_next.state != poc_pkg::POC_IDLE) && s_next.cal_elec;
		s_next.avg_on    = (s_next.state != poc_pkg::POC_IDLE) && s_next.cal_avg;
		s_next.prox_integration_time_on  = (s_next.state != poc_pkg::POC_IDLE) && s_next.cal_prox_integration_time;
		s_next.irq       = s_next.done_flag && s_next.irq_en;
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_reg            <= '0;
			s_reg.mag        <= poc_pkg::RST_OFFSET_MAG;
			s_reg.sign       <= poc_pkg::RST_OFFSET_POL;
			s_reg.zero_intvl <= poc_pkg::RST_ZERO_INTVL;
			s_reg.state      <= poc_pkg::POC_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign reg_rdata_o              = s_reg.rdata;
	assign meas_start_o             = s_reg.meas_start;
	assign proximity_result_o       = s_reg.result;
	assign proximity_result_valid_o = s_reg.result_valid;
	assign prox_offset_o            = s_reg.off_applied;
	assign diode_disconnect_o       = s_reg.diode_off;
	assign cal_averaging_o          = s_reg.avg_on;
	assign cal_integration_o        = s_reg.prox_integration_time_on;
	assign zero_request_o           = s_reg.zero_req;
	assign power_on_o               = s_reg.pwr;
	assign light_sense_enable_o     = s_reg.als_en;
	assign prox_measure_enable_o    = s_reg.prox_en;
	assign pulse_control_disable_o  = s_reg.apc_dis;
	assign irq_o                    = s_reg.irq;

endmodule

`default_nettype wire

// ---- tb/poc_offset_cal_properties.sv ----
// Concurrent checks on the ports of the proximity offset calibration block.
// Assumes one clock domain; bound to every instance of the design by the bind at the foot.
`timescale 1ns/10ps
`default_nettype none

module poc_offset_cal_properties (
	input wire logic                       clock_i,
	input wire logic                       sys_rst_i,
	input wire logic [7:0]                 reg_addr_i,
	input wire logic [7:0]                 reg_wdata_i,
	input wire logic                       reg_wr_i,
	input wire logic                       reg_rd_i,
	input wire logic [7:0]                 reg_rdata_o,
	input wire logic                       meas_done_i,
	input wire logic [poc_pkg::PROX_W-1:0] raw_prox_i,
	input wire logic                       meas_start_o,
	input wire logic [poc_pkg::PROX_W-1:0] proximity_result_o,
	input wire logic                       proximity_result_valid_o,
	input wire logic signed [9:0]          prox_offset_o,
	input wire logic                       zero_request_o,
	input wire logic                       power_on_o,
	input wire logic                       light_sense_enable_o,
	input wire logic                       irq_o
);
	logic signed [17:0]          sum;
	logic [poc_pkg::PROX_W-1:0] exp_res;

	// Negative sums clamp to zero, so the expectation is kept apart from the raw sum
	assign sum = $signed({2'b00, raw_prox_i}) + prox_offset_o;

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			exp_res <= '0;
		end else begin
			exp_res <= (sum < 0) ? 16'h0000 : sum[15:0];
		end
	end

	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data not zero outside read slot");
	chk_valid_follow: assert property (meas_done_i |=> proximity_result_valid_o)
		else $error("result valid missing after measurement");
	chk_valid_cause: assert property (proximity_result_valid_o |-> $past(meas_done_i))
		else $error("result valid without measurement");
	chk_result_value: assert property (proximity_result_valid_o |-> proximity_result_o == exp_res)
		else $error("corrected result wrong");
	chk_offset_range: assert property (prox_offset_o >= -10'sd255 && prox_offset_o <= 10'sd255)
		else $error("offset outside range");
	chk_start_pulse: assert property (meas_start_o |=> !meas_start_o)
		else $error("measurement start longer than one cycle");
	chk_zero_manual: assert property (reg_wr_i && reg_addr_i == poc_pkg::ADDR_ZEROING && reg_wdata_i[7]
		|-> ##2 zero_request_o)
		else $error("manual zeroing not requested");
	chk_power_copy: assert property (reg_wr_i && reg_addr_i == poc_pkg::ADDR_SYS_CTRL
		|-> ##2 power_on_o == $past(reg_wdata_i[0], 2) && light_sense_enable_o == $past(reg_wdata_i[1], 2))
		else $error("power or light enable copy wrong");
	chk_irq_cause: assert property ($rose(irq_o) |-> $past(meas_done_i) || $past(meas_done_i, 2)
		|| $past(meas_done_i, 3) || $past(reg_wr_i) || $past(reg_wr_i, 2))
		else $error("interrupt rose without completion");
endmodule

bind poc_offset_cal poc_offset_cal_properties u_props (
	.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .meas_done_i(meas_done_i),
	.raw_prox_i(raw_prox_i), .meas_start_o(meas_start_o), .proximity_result_o(proximity_result_o),
	.proximity_result_valid_o(proximity_result_valid_o), .prox_offset_o(prox_offset_o),
	.zero_request_o(zero_request_o), .power_on_o(power_on_o), .light_sense_enable_o(light_sense_enable_o),
	.irq_o(irq_o)
);

`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the proximity offset calibration block.
// Assumes package, design and checker are compiled first; the bench plays host and measurement engine.
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic                       clock_i            = 1'b0;
	logic                       sys_rst_i          = 1'b1;
	logic [7:0]                 reg_addr_i         = 8'h00;
	logic [7:0]                 reg_wdata_i        = 8'h00;
	logic                       reg_wr_i           = 1'b0;
	logic                       reg_rd_i           = 1'b0;
	logic                       frame_sync_i       = 1'b0;
	logic [poc_pkg::DELAY_W-1:0] prox_start_delay_i = 16'h0005;
	logic [poc_pkg::PROX_W-1:0] cal_target_i       = 16'h0064;
	logic                       meas_done_i        = 1'b0;
	logic [poc_pkg::PROX_W-1:0] raw_prox_i         = 16'h0000;
	logic                       als_cycle_i        = 1'b0;
	logic                       zero_done_i        = 1'b0;
	logic [7:0]                 reg_rdata_o;
	logic [poc_pkg::PROX_W-1:0] proximity_result_o;
	logic signed [9:0]          prox_offset_o;
	logic                       meas_start_o, proximity_result_valid_o, diode_disconnect_o, irq_o;
	logic                       cal_averaging_o, cal_integration_o, zero_request_o, power_on_o;
	logic                       light_sense_enable_o, prox_measure_enable_o, pulse_control_disable_o;
	int                         fails = 0;
	int                         tests_run = 0;
	int                         mcount = 0;
	int                         zcount = 0;
	int                         z0;
	logic [7:0]  om [4] = '{8'h10, 8'h10, 8'hff, 8'hff};
	logic [7:0]  os [4] = '{8'h00, 8'h01, 8'h01, 8'h00};
	logic [15:0] orw [4] = '{16'h0100, 16'h0100, 16'h0010, 16'h0100};
	logic [15:0] oe [4] = '{16'h0110, 16'h00f0, 16'h0000, 16'h01ff};
	logic [7:0]  iv [3] = '{8'h00, 8'h03, 8'h7f};
	logic [15:0] ie [3] = '{16'h0000, 16'h0002, 16'h0001};

	poc_offset_cal DUT (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .frame_sync_i(frame_sync_i),
		.prox_start_delay_i(prox_start_delay_i), .cal_target_i(cal_target_i), .meas_done_i(meas_done_i),
		.raw_prox_i(raw_prox_i), .als_cycle_i(als_cycle_i), .zero_done_i(zero_done_i),
		.meas_start_o(meas_start_o), .proximity_result_o(proximity_result_o),
		.proximity_result_valid_o(proximity_result_valid_o), .prox_offset_o(prox_offset_o),
		.diode_disconnect_o(diode_disconnect_o), .cal_averaging_o(cal_averaging_o),
		.cal_integration_o(cal_integration_o), .zero_request_o(zero_request_o), .power_on_o(power_on_o),
		.light_sense_enable_o(light_sense_enable_o), .prox_measure_enable_o(prox_measure_enable_o),
		.pulse_control_disable_o(pulse_control_disable_o), .irq_o(irq_o)
	);

	initial begin
		forever #5 clock_i = ~clock_i;
	end

	// Counts request pulses and finishes every zeroing one cycle after it is asked for
	always @(posedge clock_i) begin
		if (meas_start_o === 1'b1) mcount++;
		if (zero_request_o === 1'b1) zcount++;
		zero_done_i <= zero_request_o;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string name);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		@(posedge clock_i);
		chk(name, {8'h00, e}, {8'h00, reg_rdata_o});
	endtask

	task automatic meas(input logic [15:0] raw, input logic [15:0] e);
		@(posedge clock_i);
		meas_done_i <= 1'b1;
		raw_prox_i  <= raw;
		@(posedge clock_i);
		meas_done_i <= 1'b0;
		@(posedge clock_i);
		chk("valid", 16'h0001, {15'h0, proximity_result_valid_o});
		chk("result", e, proximity_result_o);
	endtask

	// Acts as the measurement engine; raw reading 300 stands for a fixed crosstalk level
	task automatic run_cal(input bit sync, input logic [7:0] ctl, input logic [7:0] sysv);
		int k;
		int m0;
		int m1;
		m0 = mcount;
		wr(poc_pkg::ADDR_CAL_CTRL, ctl);
		if (!ctl[5]) begin
			tick(20);
			chk("waitpwr", 16'(m0), 16'(mcount));
			wr(poc_pkg::ADDR_SYS_CTRL, sysv);
		end
		repeat (9) begin
			m1 = mcount;
			if (sync) begin
				tick(30);
				chk("nosync", 16'(m1), 16'(mcount));
				frame_sync_i <= 1'b1;
			end
			k = 0;
			while (meas_start_o !== 1'b1 && k < 200) begin
				@(posedge clock_i);
				k++;
				if (k == 3) frame_sync_i <= 1'b0;
			end
			if (sync) chk("delay", 16'h0001, {15'h0, k > 5 && k < 14});
			chk("diode", {15'h0, ctl[5]}, {15'h0, diode_disconnect_o});
			chk("avg", {15'h0, ctl[7]}, {15'h0, cal_averaging_o});
			chk("prox_integration_time", {15'h0, ctl[4]}, {15'h0, cal_integration_o});
			tick(2);
			meas_done_i <= 1'b1;
			raw_prox_i  <= 16'd300;
			@(posedge clock_i);
			meas_done_i <= 1'b0;
		end
		tick(40);
		chk("cycles", 16'd9, 16'(mcount - m0));
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Whole run needs under a thousand cycles
	initial begin
		tick(30000);
		fails++;
		$display("BAD watchdog expected finish seen hang");
		complete_run();
	end

	initial begin
		tick(4);
		sys_rst_i <= 1'b0;
		rd(poc_pkg::ADDR_OFFSET_MAG, 8'h00, "mag");
		rd(poc_pkg::ADDR_OFFSET_POL, 8'h00, "pol");
		rd(poc_pkg::ADDR_ZEROING, 8'h7f, "zeroing");
		rd(poc_pkg::ADDR_CAL_CTRL, 8'h00, "calctl");
		wr(poc_pkg::ADDR_SYS_CTRL, 8'h04);
		rd(poc_pkg::ADDR_SYS_CTRL, 8'h04, "sysctl");
		chk("proxen", 16'h0002, {14'h0, prox_measure_enable_o, pulse_control_disable_o});
		wr(poc_pkg::ADDR_OFFSET_MAG, 8'ha5);
		rd(poc_pkg::ADDR_OFFSET_MAG, 8'ha5, "mag");
		wr(poc_pkg::ADDR_OFFSET_POL, 8'hff);
		rd(poc_pkg::ADDR_OFFSET_POL, 8'h01, "pol");
		wr(8'h55, 8'hff);
		rd(8'h55, 8'h00, "unmapped");
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			wr(poc_pkg::ADDR_OFFSET_MAG, om[i]);
			wr(poc_pkg::ADDR_OFFSET_POL, os[i]);
			meas(orw[i], oe[i]);
		end
		$display("test offset done");
		wr(poc_pkg::ADDR_SYS_CTRL, 8'h01);
		z0 = zcount;
		wr(poc_pkg::ADDR_ZEROING, 8'h80);
		tick(10);
		chk("manual", 16'h0001, 16'(zcount - z0));
		rd(poc_pkg::ADDR_ZEROING, 8'h00, "selfclear");
		for (int i = 0; i < 3; i++) begin
			wr(poc_pkg::ADDR_SYS_CTRL, 8'h01);
			wr(poc_pkg::ADDR_ZEROING, iv[i]);
			z0 = zcount;
			wr(poc_pkg::ADDR_SYS_CTRL, 8'h03);
			repeat (6) begin
				@(posedge clock_i);
				als_cycle_i <= 1'b1;
				@(posedge clock_i);
				als_cycle_i <= 1'b0;
				tick(3);
			end
			tick(5);
			chk("interval", ie[i], 16'(zcount - z0));
		end
		$display("test zeroing done");
		wr(poc_pkg::ADDR_SYS_CTRL, 8'h28);
		run_cal(1'b0, 8'hb1, 8'h28);
		rd(poc_pkg::ADDR_OFFSET_MAG, 8'hc8, "calmag");
		rd(poc_pkg::ADDR_OFFSET_POL, 8'h01, "calpol");
		rd(poc_pkg::ADDR_CAL_CTRL, 8'hb0, "selfclr");
		rd(poc_pkg::ADDR_CAL_STATUS, 8'h01, "done");
		chk("irq", 16'h0001, {15'h0, irq_o});
		chk("idle", 16'h0001, {14'h0, prox_measure_enable_o, pulse_control_disable_o});
		wr(poc_pkg::ADDR_CAL_STATUS, 8'h01);
		tick(2);
		chk("irqclr", 16'h0000, {15'h0, irq_o});
		$display("test electrical done");
		cal_target_i <= 16'h0000;
		wr(poc_pkg::ADDR_SYS_CTRL, 8'h08);
		run_cal(1'b0, 8'h01, 8'h09);
		rd(poc_pkg::ADDR_OFFSET_MAG, 8'hff, "calmag");
		rd(poc_pkg::ADDR_OFFSET_POL, 8'h01, "calpol");
		rd(poc_pkg::ADDR_CAL_CTRL, 8'h00, "selfclr");
		chk("irqoff", 16'h0000, {15'h0, irq_o});
		wr(poc_pkg::ADDR_CAL_STATUS, 8'h01);
		$display("test optical done");
		cal_target_i <= 16'h0064;
		wr(poc_pkg::ADDR_SYS_CTRL, 8'h19);
		run_cal(1'b1, 8'h21, 8'h19);
		rd(poc_pkg::ADDR_OFFSET_MAG, 8'hc8, "syncmag");
		$display("test frame sync done");
		complete_run();
	end
endmodule

`default_nettype wire
